//--- inc/aqrx_pkg.sv
// constants and types for the four-channel receiver with one transmitter
// assumes one 200 MHz core clock; every slower rate is a one-cycle enable
package aqrx_pkg;
  localparam int unsigned NUM_CH = 4;
  // byte address pins, two-step addressing
  localparam logic [1:0] ADDR_BYTE0 = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_BYTE2 = 2'h2;
  localparam logic [1:0] ADDR_TOP = 2'h3;
  // control bit positions
  localparam int unsigned CTRL_PROG_BIT = 4;
  localparam int unsigned CTRL_GO_BIT = 5;
  localparam int unsigned CTRL_LOOP_BIT = 6;
  localparam int unsigned CTRL_MASK_BIT = 7;
  // status bit positions
  localparam int unsigned STAT_DONE_BIT = 4;
  localparam int unsigned STAT_ACTIVE_BIT = 7;
  // sync/enable register
  localparam int unsigned SYNC_ENABLE_BIT = 7;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LABEL_RESET = 8'h00;
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [23:0] BUFFER_RESET = 24'h000000;
  // timing counts: prescale in core clock cycles, sync values in eight-cycle steps, tx gap in bit periods
  localparam logic [2:0] GAP_PRESCALE_MAX = 3'h7;
  localparam logic [6:0] SYNC_HIGH_SPEED = 7'h05;
  localparam logic [6:0] SYNC_LOW_SPEED = 7'h20;
  localparam logic [6:0] GAP_COUNT_MAX = 7'h7F;
  localparam logic [2:0] TX_GAP_PERIODS = 3'h4;
  localparam logic [5:0] WORD_BITS = 6'h20;
  // transmit byte queue
  localparam int unsigned TXQ_WIDTH = 10;
  localparam int unsigned TXQ_DEPTH = 8;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_GAP = 2'b10
  } aqrx_tx_state_t;
endpackage

//--- src/aqrx_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes both sides on the core clock; full and empty are registered
`timescale 1ns/10ps
module aqrx_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic full;
  logic empty;
  wire push = i_in_valid & ~full;
  wire pop = i_out_ready & ~empty;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data = mem[rd_ptr];
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
      empty <= 1'b1;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      full <= (next_count == (AW+1)'(DEPTH));
      empty <= (next_count == '0);
    end
  end
endmodule

//--- src/aqrx_top.sv
// four-channel two-wire serial receiver with one transmitter and byte bus
// assumes bus, line and strap pins are asynchronous to the core clock
//
// Operation
// - channel flag sets on accept, clears on read
// - interrupt low for flags or unmasked done, first mode only
// - done on completion, active during sending
// - control select bits address receive channels
// - program bit opens tx loading, clears done when written
// - go bit sends 32 bits, then clears
// - repeated go resends after four periods
// - loopback routes tx lines into selected channel
// - divider square wave, low bit forced zero
// - enable bit low blocks channel transfers in first mode
// - gap delay is (8n - 4) plus minus 4
// - bit clock is OR of both lines
// - falling clock resets gap counter, eight-cycle steps
// - transfer needs gap, no read, parity, label
// - label match moves 24 bits, sets flag
// - second mode moves label and payload, no match
// - even ones discarded when parity checked
// - read of first bytes holds off transfer
// - scan counter cycles channels unless held
// - modulo-4 load index, reset by control access
// - reset clears control, status, labels, syncs
// - first gap after reset is ignored
// - second mode sync fixed by speed strap
`timescale 1ns/10ps
module aqrx_top
  import aqrx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_chip_select_n,
  input wire logic [1:0] i_byte_addr_pins,
  input wire logic i_dir_or_scan_hold,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  input wire logic i_mode_b,
  input wire logic i_parity_en,
  input wire logic [1:0] i_speed_strap,
  input wire logic [aqrx_pkg::NUM_CH-1:0] i_line_one_in,
  input wire logic [aqrx_pkg::NUM_CH-1:0] i_line_zero_in,
  output logic [1:0] o_scan_channel_out,
  output logic o_interrupt_out_n,
  output logic o_irq_oe,
  output logic o_tx_load_ready
);
  import aqrx_pkg::*;

  // two-flop synchronisers for every pin
  logic cs_m, cs_s, cs_q, rw_m, rw_s, modeb_m, mode_b, par_m, par_en;
  logic [1:0] addr_m, addr_s, strap_m, strap_s;
  logic [7:0] data_m, data_s;
  logic [NUM_CH-1:0] one_m, one_s, zero_m, zero_s;
  always_ff @(posedge i_core_clk) begin
    cs_m <= i_chip_select_n;
    cs_s <= cs_m;
    rw_m <= i_dir_or_scan_hold;
    rw_s <= rw_m;
    addr_m <= i_byte_addr_pins;
    addr_s <= addr_m;
    data_m <= i_data;
    data_s <= data_m;
    modeb_m <= i_mode_b;
    mode_b <= modeb_m;
    par_m <= i_parity_en;
    par_en <= par_m;
    strap_m <= i_speed_strap;
    strap_s <= strap_m;
    one_m <= i_line_one_in;
    one_s <= one_m;
    zero_m <= i_line_zero_in;
    zero_s <= zero_m;
  end

  logic [7:0] ctrl;
  logic [7:0] divider;
  logic tx_done;
  logic [1:0] stack_idx;
  logic [1:0] scan;
  logic [NUM_CH-1:0][7:0] rx_label;
  logic [NUM_CH-1:0][7:0] rx_sync;
  logic [NUM_CH-1:0][23:0] rx_buf;
  logic [NUM_CH-1:0] rx_flags, rx_lock, rx_accept;
  aqrx_tx_state_t tx_state;

  // bus access framing: start on select fall, writes land on select rise
  logic acc_read;
  logic [1:0] acc_addr, acc_ch;
  logic [7:0] wr_data;
  wire acc_start = cs_q & ~cs_s;
  wire acc_end = ~cs_q & cs_s;
  wire read_now = mode_b | rw_s;
  wire wr_end = acc_end & ~mode_b & ~acc_read;
  wire prog = ctrl[CTRL_PROG_BIT];
  // a read at this address is a payload byte, not the control register
  wire ctrl_touch = acc_start & ~mode_b & ~read_now & (addr_s == ADDR_CTRL);
  wire wr_ctrl = wr_end & (acc_addr == ADDR_CTRL);
  wire wr_div = wr_end & (acc_addr == ADDR_BYTE0) & prog;
  wire wr_sync = wr_end & (acc_addr == ADDR_BYTE0) & ~prog;
  wire wr_stack = wr_end & (acc_addr == ADDR_TOP) & prog;
  wire wr_label = wr_end & (acc_addr == ADDR_TOP) & ~prog;
  wire [1:0] sel_idx = ctrl[0] ? 2'h0 : ctrl[1] ? 2'h1 : ctrl[2] ? 2'h2 : ctrl[3] ? 2'h3 : 2'h0;
  wire [1:0] rd_ch = mode_b ? scan : sel_idx;
  wire rd_lock_set = acc_start & read_now & ((addr_s == ADDR_BYTE0) | (addr_s == ADDR_CTRL));
  wire rd_last = acc_end & acc_read & (acc_addr == ADDR_BYTE2);
  wire [7:0] status = {tx_state == TX_SEND, 2'b00, tx_done, rx_flags};
  wire [23:0] rd_buf = rx_buf[rd_ch];
  wire [7:0] rd_mux = (addr_s == ADDR_TOP) ? (mode_b ? rx_label[rd_ch] : status) :
                      (addr_s == ADDR_BYTE0) ? rd_buf[7:0] :
                      (addr_s == ADDR_CTRL) ? rd_buf[15:8] : rd_buf[23:16];

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cs_q <= 1'b1;
      acc_read <= 1'b1;
      acc_addr <= 2'h0;
      acc_ch <= 2'h0;
      wr_data <= 8'h00;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      cs_q <= cs_s;
      if (acc_start) begin
        acc_read <= read_now;
        acc_addr <= addr_s;
        acc_ch <= rd_ch;
      end
      if (!cs_s) begin
        wr_data <= data_s;
      end
      o_data <= rd_mux;
      o_data_oe <= ~cs_s & read_now;
    end
  end

  // control register, done flag and load index
  wire tx_done_pulse;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl <= CTRL_RESET;
      divider <= DIV_RESET;
      tx_done <= 1'b0;
      stack_idx <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wr_data;
      end else begin
        if (ctrl_touch) ctrl[CTRL_LOOP_BIT] <= 1'b0;
        if (tx_done_pulse) ctrl[CTRL_GO_BIT] <= 1'b0;
      end
      tx_done <= tx_done_pulse | (tx_done & ~(wr_ctrl & wr_data[CTRL_PROG_BIT]));
      if (ctrl_touch) begin
        stack_idx <= 2'h0;
      end else if (wr_stack) begin
        stack_idx <= stack_idx + 2'h1;
      end
      if (wr_div) divider <= wr_data;
    end
  end

  // queued byte loads let a write land while a word is still shifting
  logic q_valid, q_in_ready;
  logic [TXQ_WIDTH-1:0] q_data;
  logic [3:0][7:0] tx_stack;
  wire q_ready = (tx_state != TX_SEND);
  aqrx_fifo #(.WIDTH(TXQ_WIDTH), .DEPTH(TXQ_DEPTH)) u_txq (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_in_valid(wr_stack),
    .o_in_ready(q_in_ready),
    .i_in_data({stack_idx, wr_data}),
    .o_out_valid(q_valid),
    .i_out_ready(q_ready),
    .o_out_data(q_data)
  );
  assign o_tx_load_ready = q_in_ready;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_stack <= '0;
    end else if (q_valid && q_ready) begin
      tx_stack[q_data[9:8]] <= q_data[7:0];
    end
  end

  // transmitter: half period is n/2 cycles since the low bit reads as zero
  logic [6:0] half_cnt;
  logic phase;
  logic [31:0] tx_shift;
  logic [5:0] tx_bits;
  logic [2:0] tx_gap;
  logic tx_one, tx_zero;
  wire [6:0] half_len = (divider[7:1] == 7'h00) ? 7'h01 : divider[7:1];
  wire half_tick = (half_cnt == half_len - 7'h01);
  wire go = ctrl[CTRL_GO_BIT];
  wire can_start = go & ~q_valid;
  assign tx_done_pulse = (tx_state == TX_SEND) & half_tick & phase & (tx_bits == WORD_BITS - 6'h01);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_state <= TX_IDLE;
      half_cnt <= 7'h00;
      phase <= 1'b0;
      tx_shift <= 32'h0000_0000;
      tx_bits <= 6'h00;
      tx_gap <= 3'h0;
      tx_one <= 1'b0;
      tx_zero <= 1'b0;
    end else begin
      half_cnt <= half_tick ? 7'h00 : half_cnt + 7'h01;
      if (half_tick) phase <= ~phase;
      case (tx_state)
        TX_IDLE: begin
          // start on go with all bytes loaded
          if (can_start && half_tick && phase) begin
            tx_state <= TX_SEND;
            tx_shift <= tx_stack;
            tx_bits <= 6'h00;
          end
        end
        TX_SEND: begin
          if (half_tick && !phase) begin
            tx_one <= tx_shift[0];
            tx_zero <= ~tx_shift[0];
          end else if (half_tick && phase) begin
            tx_one <= 1'b0;
            tx_zero <= 1'b0;
            tx_shift <= {tx_shift[0], tx_shift[31:1]};
            tx_bits <= tx_bits + 6'h01;
            if (tx_done_pulse) begin
              tx_state <= TX_GAP;
              tx_gap <= 3'h0;
            end
          end
        end
        TX_GAP: begin
          // four silent periods before a resend
          if (half_tick && phase) begin
            tx_gap <= tx_gap + 3'h1;
            if (tx_gap == TX_GAP_PERIODS - 3'h1) begin
              tx_state <= can_start ? TX_SEND : TX_IDLE;
              tx_bits <= 6'h00;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // loopback replaces the selected channel's line inputs
  wire loop_on = ctrl[CTRL_LOOP_BIT] & go;
  wire [NUM_CH-1:0] sel_onehot = 4'h1 << sel_idx;
  wire [NUM_CH-1:0] loop_mask = (loop_on && ctrl[3:0] != 4'h0) ? sel_onehot : 4'h0;
  wire [NUM_CH-1:0] rx_one = (one_s & ~loop_mask) | (loop_mask & {NUM_CH{tx_one}});
  wire [NUM_CH-1:0] rx_zero = (zero_s & ~loop_mask) | (loop_mask & {NUM_CH{tx_zero}});

  // shared eight-cycle step for the gap counters
  logic [2:0] prescale;
  wire gap_step = (prescale == GAP_PRESCALE_MAX);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) prescale <= 3'h0;
    else prescale <= prescale + 3'h1;
  end

  genvar gi;
  for (gi = 0; gi < NUM_CH; gi++) begin : g_rx
    logic rclk_q, gap_done, first_seen, armed, par;
    logic [31:0] shift;
    logic [5:0] bits;
    logic [6:0] gcnt;
    wire rclk = rx_one[gi] | rx_zero[gi];
    wire rise = rclk & ~rclk_q;
    wire fall = ~rclk & rclk_q;
    // strapped sync values in second mode
    wire [6:0] n_eff = mode_b ? ((2'(gi) < strap_s) ? SYNC_HIGH_SPEED : SYNC_LOW_SPEED)
                              : rx_sync[gi][6:0];
    // gap after n steps of eight cycles
    wire gap_ev = gap_step & ~gap_done & (n_eff != 7'h00) & (gcnt + 7'h01 == n_eff);
    wire label_ok = mode_b | (rx_sync[gi][SYNC_ENABLE_BIT] & (shift[7:0] == rx_label[gi]));
    assign rx_accept[gi] = gap_ev & armed & (bits == WORD_BITS) & ~rx_lock[gi]
                           & (~par_en | par) & label_ok;
    wire clr = rd_last & (acc_ch == 2'(gi));
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        rclk_q <= 1'b0;
        gap_done <= 1'b0;
        first_seen <= 1'b0;
        armed <= 1'b0;
        par <= 1'b0;
        shift <= 32'h0000_0000;
        bits <= 6'h00;
        gcnt <= 7'h00;
        rx_flags[gi] <= 1'b0;
        rx_lock[gi] <= 1'b0;
        rx_label[gi] <= LABEL_RESET;
        rx_sync[gi] <= SYNC_RESET;
        rx_buf[gi] <= BUFFER_RESET;
      end else begin
        rclk_q <= rclk;
        if (rise) begin
          shift <= {rx_one[gi], shift[31:1]};
          par <= par ^ rx_one[gi];
          if (bits != WORD_BITS) bits <= bits + 6'h01;
        end
        // falling edge restarts the gap count
        if (fall) begin
          gcnt <= 7'h00;
          gap_done <= 1'b0;
        end else if (gap_step && gcnt != GAP_COUNT_MAX) begin
          gcnt <= gcnt + 7'h01;
        end
        if (gap_ev) begin
          gap_done <= 1'b1;
          // first gap only sets first_seen; the second gap arms
          first_seen <= 1'b1;
          armed <= first_seen;
          bits <= 6'h00;
          par <= 1'b0;
        end
        if (rx_accept[gi]) begin
          rx_buf[gi] <= shift[31:8];
          // label taken from the word in second mode
          if (mode_b) rx_label[gi] <= shift[7:0];
        end
        rx_flags[gi] <= rx_accept[gi] | (rx_flags[gi] & ~clr);
        // hold off from first read to last byte
        if (rd_lock_set && rd_ch == 2'(gi)) rx_lock[gi] <= 1'b1;
        else if (clr) rx_lock[gi] <= 1'b0;
        if (wr_sync && ctrl[gi]) rx_sync[gi] <= wr_data;
        if (wr_label && ctrl[gi]) rx_label[gi] <= wr_data;
      end
    end
  end

  // scan counter, held by the direction pin
  always_ff @(posedge i_core_clk) begin
    if (i_rst) scan <= 2'h0;
    else if (mode_b && !rw_s) scan <= scan + 2'h1;
  end

  // interrupt drive; the pin is a strap input in second mode
  wire irq_on = ~mode_b & ((|rx_flags) | (tx_done & ~ctrl[CTRL_MASK_BIT]));
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_interrupt_out_n <= 1'b1;
      o_irq_oe <= 1'b0;
      o_scan_channel_out <= 2'h0;
    end else begin
      o_interrupt_out_n <= ~irq_on;
      o_irq_oe <= irq_on;
      // pins carry the tx lines in first mode, the scanned channel in second
      o_scan_channel_out <= mode_b ? scan : {tx_one, tx_zero};
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_flag_on_accept: assert property (rx_accept[0] |=> rx_flags[0])
    else $error("flag not set after accept");
  a_irq_from_flags: assert property (!mode_b && rx_flags != 4'h0 |=> !o_interrupt_out_n)
    else $error("interrupt not driven for flag");
  a_irq_masked: assert property (!mode_b && rx_flags == 4'h0 && ctrl[CTRL_MASK_BIT]
    |=> o_interrupt_out_n)
    else $error("masked done drove interrupt");
  a_active_sending: assert property (tx_state == TX_SEND |-> status[STAT_ACTIVE_BIT])
    else $error("active flag low while sending");
  a_go_clears: assert property (tx_done_pulse && !wr_ctrl |=> !ctrl[CTRL_GO_BIT] && tx_done)
    else $error("go not cleared at word end");
  a_resend_gap: assert property ($rose(tx_state == TX_SEND) && $past(tx_state) == TX_GAP
    |-> $past(tx_gap) == TX_GAP_PERIODS - 3'h1)
    else $error("resend gap length wrong");
  a_half_len: assert property (half_tick |-> half_cnt == half_len - 7'h01)
    else $error("divider half period wrong");
  a_parity_gate: assert property (rx_accept[1] |-> !par_en || g_rx[1].par)
    else $error("even word accepted");
  a_lock_blocks: assert property (rx_lock[0] |-> !rx_accept[0])
    else $error("transfer during read");
  a_disabled_chan: assert property (!mode_b && !rx_sync[2][SYNC_ENABLE_BIT]
    |-> !rx_accept[2])
    else $error("disabled channel accepted");
  a_scan_hold: assert property (mode_b && !rw_s ##1 mode_b && rw_s
    |=> scan == $past(scan))
    else $error("scan moved while held");
endmodule

//--- verif/aqrx_line_src.sv
// partner model: line drivers of four serial channels, one word at a time
// assumes the design synchronises the lines; both lines low is the null level
`timescale 1ns/10ps
module aqrx_line_src #(
  parameter int HALF = 8
) (
  input wire logic i_core_clk,
  output logic [3:0] o_one,
  output logic [3:0] o_zero
);
  initial begin
    o_one = 4'h0;
    o_zero = 4'h0;
  end
  // return-to-zero pulse on one line per bit, lsb first
  task automatic send(input int ch, input logic [31:0] w);
    for (int b = 0; b < 32; b++) begin
      @(negedge i_core_clk);
      o_one[ch] = w[b];
      o_zero[ch] = ~w[b];
      repeat (HALF) @(negedge i_core_clk);
      o_one[ch] = 1'b0;
      o_zero[ch] = 1'b0;
      repeat (HALF - 1) @(negedge i_core_clk);
    end
    // silence well beyond the gap delay so the word is closed off
    repeat (8 * HALF) @(negedge i_core_clk);
  endtask
endmodule

//--- verif/aqrx_top_tb.sv
// self-checking bench: host byte bus tasks, line source model on receive side
// assumes the design top and aqrx_line_src; one 200 MHz core clock
`timescale 1ns/10ps
module aqrx_top_tb;
  import aqrx_pkg::*;
  localparam logic [31:0] TXW = 32'h372211A5;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cs_n = 1'b1;
  logic [1:0] addr = 2'h0;
  logic dir = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic mode_b = 1'b0;
  logic par_en = 1'b1;
  logic [7:0] o_data;
  logic o_data_oe, o_irq_oe, o_int_n, ld_rdy;
  logic [1:0] o_scan;
  logic [1:0] sc;
  logic [3:0] l_one, l_zero;
  // host drives the bus only while the device is not reading out
  wire [7:0] bus_d = o_data_oe ? o_data : wdata;
  // open-drain interrupt with pull-up
  wire irq_n = o_irq_oe ? 1'b0 : 1'b1;
  int n_fail = 0;
  int num_checks = 0;
  logic cap_en = 1'b0;
  logic tx_q = 1'b0;
  logic [31:0] cap = 32'h0;
  int ncap = 0, t0 = 0, cyc = 0, period = 0;

  aqrx_top i_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_chip_select_n(cs_n),
    .i_byte_addr_pins(addr), .i_dir_or_scan_hold(dir), .i_data(bus_d),
    .o_data(o_data), .o_data_oe(o_data_oe), .i_mode_b(mode_b), .i_parity_en(par_en),
    .i_speed_strap(2'h0), .i_line_one_in(l_one), .i_line_zero_in(l_zero),
    .o_scan_channel_out(o_scan), .o_interrupt_out_n(o_int_n), .o_irq_oe(o_irq_oe),
    .o_tx_load_ready(ld_rdy)
  );
  aqrx_line_src #(.HALF(8)) u_src (
    .i_core_clk(i_core_clk), .o_one(l_one), .o_zero(l_zero)
  );

  always #2.5 i_core_clk = ~i_core_clk;

  // transmit line monitor: one bit per rising edge of the or of both lines
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    tx_q <= |o_scan;
    if (cap_en && !mode_b && (|o_scan) && !tx_q && ncap < 32) begin
      cap <= {o_scan[1], cap[31:1]};
      ncap <= ncap + 1;
      if (ncap == 0) t0 <= cyc;
      if (ncap == 1) period <= cyc - t0;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // phases held well past the two-stage synchronisers
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    cs_n = 1'b0;
    addr = a;
    dir = 1'b0;
    wdata = d;
    repeat (6) @(negedge i_core_clk);
    cs_n = 1'b1;
    repeat (6) @(negedge i_core_clk);
  endtask

  task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    cs_n = 1'b0;
    addr = a;
    dir = 1'b1;
    repeat (8) @(negedge i_core_clk);
    d = o_data;
    cs_n = 1'b1;
    repeat (6) @(negedge i_core_clk);
    dir = 1'b0;
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] v;
    bus_rd(a, v);
    chk({24'h0, v}, {24'h0, e});
  endtask

  // status, then payload of the flagged channel, then status after the last byte
  task automatic drain(input logic [31:0] w, input logic [7:0] st, input logic [7:0] rest);
    rd_chk(ADDR_TOP, st);
    if (st[3:0] != 4'h0) begin
      chk({31'h0, irq_n}, 32'h0);
      bus_wr(ADDR_CTRL, {4'h0, st[3:0]});
      rd_chk(ADDR_BYTE0, w[15:8]);
      rd_chk(ADDR_CTRL, w[23:16]);
      rd_chk(ADDR_BYTE2, w[31:24]);
      rd_chk(ADDR_TOP, rest);
    end
    chk({31'h0, irq_n}, {31'h0, ~(|rest)});
  endtask

  task automatic rx_case(input int ch, input logic [31:0] w, input logic [7:0] st);
    u_src.send(ch, w);
    drain(w, st, 8'h00);
  endtask

  initial begin
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_core_clk);
    rd_chk(ADDR_TOP, 8'h00);
    chk({31'h0, irq_n}, 32'h1);
    chk({31'h0, ld_rdy}, 32'h1);
    bus_wr(ADDR_CTRL, 8'h03);
    bus_wr(ADDR_TOP, 8'hA5);
    bus_wr(ADDR_BYTE0, 8'h85);
    bus_wr(ADDR_CTRL, 8'h02);
    bus_wr(ADDR_TOP, 8'h3C);
    // first gap is ignored, so the word after it is dropped too: prime twice
    for (int p = 0; p < 2; p++) begin
      u_src.send(0, 32'h00000001);
      u_src.send(1, 32'h00000001);
    end
    rx_case(0, 32'h123456A5, 8'h01);
    rx_case(0, 32'h123457A5, 8'h00);
    rx_case(1, 32'hABCDEF3C, 8'h02);
    rx_case(1, 32'h123456A5, 8'h00);
    bus_wr(ADDR_CTRL, 8'h11);
    bus_wr(ADDR_BYTE0, 8'h05);
    for (int i = 0; i < 4; i++) bus_wr(ADDR_TOP, TXW[8*i +: 8]);
    cap_en = 1'b1;
    bus_wr(ADDR_CTRL, 8'h61);
    rd_chk(ADDR_TOP, 8'h80);
    for (int k = 0; k < 400 && ncap < 32; k++) @(negedge i_core_clk);
    chk(cap, TXW);
    chk(period, 32'h4);
    repeat (80) @(negedge i_core_clk);
    drain(TXW, 8'h11, 8'h10);
    bus_wr(ADDR_CTRL, 8'h80);
    chk({31'h0, irq_n}, 32'h1);
    rd_chk(ADDR_TOP, 8'h10);
    bus_wr(ADDR_CTRL, 8'h10);
    rd_chk(ADDR_TOP, 8'h00);
    bus_wr(ADDR_CTRL, 8'h01);
    bus_wr(ADDR_BYTE0, 8'h05);
    rx_case(0, 32'h123456A5, 8'h00);
    mode_b = 1'b1;
    repeat (6) @(negedge i_core_clk);
    sc = o_scan;
    for (int i = 0; i < 4; i++) begin
      @(negedge i_core_clk);
      chk({30'h0, o_scan}, {30'h0, sc + 2'h1});
      sc = o_scan;
    end
    dir = 1'b1;
    repeat (6) @(negedge i_core_clk);
    sc = o_scan;
    @(negedge i_core_clk);
    chk({30'h0, o_scan}, {30'h0, sc});
    stop_test();
  end

  // whole run is under 10000 cycles; twice that means a hang
  initial begin
    repeat (20000) @(negedge i_core_clk);
    n_fail++;
    stop_test();
  end
endmodule
